/* verilog/dgsp_pkg.sv */
// Constants for the dual GPIO / LCD segment port block
`default_nettype none

package dgsp_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [15:0] IDX_FIRST_LATCH  = 16'hFFD9;
	localparam logic [15:0] IDX_FIRST_DIR    = 16'hFFE9;
	localparam logic [15:0] IDX_FIRST_PULLUP = 16'hFFE3;
	localparam logic [15:0] IDX_SECOND_LATCH = 16'hFFDA;
	localparam logic [15:0] IDX_SECOND_DIR   = 16'hFFEA;
	localparam logic [15:0] IDX_LCD_PIN_CTRL = 16'hFFF0;

	// Register widths and reset values
	localparam int          PORT_W       = 8;
	localparam int          SGS_W        = 4;
	localparam logic [7:0]  RST_LATCH    = 8'h00;
	localparam logic [7:0]  RST_DIR      = 8'h00;
	localparam logic [7:0]  RST_PULLUP   = 8'h00;
	localparam logic [3:0]  RST_SGS      = 4'h0;
	localparam logic [7:0]  WO_READ_BACK = 8'hFF;

	// Bus geometry
	localparam int          APB_ADDR_W   = 18;
	localparam int          IDX_LSB      = 2;

	// Operating modes reported by the power controller
	localparam logic [2:0]  MODE_ACTIVE    = 3'h0;
	localparam logic [2:0]  MODE_SUBACTIVE = 3'h1;
	localparam logic [2:0]  MODE_SLEEP     = 3'h2;
	localparam logic [2:0]  MODE_SUBSLEEP  = 3'h3;
	localparam logic [2:0]  MODE_WATCH     = 3'h4;
	localparam logic [2:0]  MODE_STANDBY   = 3'h5;

endpackage : dgsp_pkg

`default_nettype wire

/* verilog/dgsp_sync.sv */
// Two flip-flop synchroniser for pin inputs
`default_nettype none

module dgsp_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	// First stage read only by the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : dgsp_sync

`default_nettype wire

/* verilog/dgsp_pin_stage.sv */
// Registered pad drive stage with hold and standby handling
`default_nettype none

module dgsp_pin_stage #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Mode qualifiers
	input  wire logic         standby,
	input  wire logic         hold,
	// Functional values
	input  wire logic [W-1:0] func_oe,
	input  wire logic [W-1:0] func_o,
	input  wire logic [W-1:0] func_pu,
	// Pad controls
	output logic      [W-1:0] pad_oe,
	output logic      [W-1:0] pad_o,
	output logic      [W-1:0] pad_pu
);

	logic [W-1:0] oe_next;
	logic [W-1:0] o_next;
	logic [W-1:0] pu_next;

	// Standby floats drivers but keeps pull-ups; hold freezes everything
	assign oe_next = standby ? '0 : (hold ? pad_oe : func_oe);
	assign o_next  = standby ? '0 : (hold ? pad_o : func_o);
	assign pu_next = standby ? func_pu : (hold ? pad_pu : func_pu);

	// Pads float from reset onward
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_oe <= '0;
			pad_o  <= '0;
			pad_pu <= '0;
		end else begin
			pad_oe <= oe_next;
			pad_o  <= o_next;
			pad_pu <= pu_next;
		end
	end

endmodule : dgsp_pin_stage

`default_nettype wire

/* verilog/dgsp_port.sv */
// Two 8-bit GPIO ports sharing pins with LCD segment outputs
`default_nettype none

module dgsp_port #(
	parameter int W = dgsp_pkg::PORT_W
) (
	// Clock and reset
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	// APB slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [dgsp_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                     pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// Power controller
	input  wire logic [2:0]                      pwr_mode,
	// LCD driver segment data
	input  wire logic [W-1:0]                    lcd_segment_output_first,
	input  wire logic [W-1:0]                    lcd_segment_output_second,
	// First port pads
	input  wire logic [W-1:0]                    first_port_pin_i,
	output logic      [W-1:0]                    first_port_pin_o,
	output logic      [W-1:0]                    first_port_pin_oe,
	output logic      [W-1:0]                    first_port_pin_pu,
	// Second port pads
	input  wire logic [W-1:0]                    second_port_pin_i,
	output logic      [W-1:0]                    second_port_pin_o,
	output logic      [W-1:0]                    second_port_pin_oe
);

	// Registers
	logic [W-1:0] first_port_latch_reg;
	logic [W-1:0] first_port_direction_reg;
	logic [W-1:0] first_port_pullup_ctrl_reg;
	logic [W-1:0] second_port_latch_reg;
	logic [W-1:0] second_port_direction_reg;
	logic [3:0]   segment_select_code_reg;
	logic [31:0]  rdata_reg;
	logic         slverr_reg;
	logic [31:0]  rdata_next;
	logic         slverr_next;

	// Synchronised pin levels
	logic [W-1:0] first_pin_sync;
	logic [W-1:0] second_pin_sync;

	// Address decode
	logic [15:0]  word_idx;
	logic         aligned;
	logic         hit_first_latch;
	logic         hit_first_dir;
	logic         hit_first_pu;
	logic         hit_second_latch;
	logic         hit_second_dir;
	logic         hit_sgs;
	logic         hit_any;
	logic         setup_phase;
	logic         wr_en;
	logic [W-1:0] wbyte;

	// Pin function
	logic         first_gpio;
	logic         second_gpio;
	logic         mode_standby;
	logic         mode_hold;
	logic [W-1:0] first_read_val;
	logic [W-1:0] second_read_val;
	logic [W-1:0] first_func_oe;
	logic [W-1:0] first_func_o;
	logic [W-1:0] first_func_pu;
	logic [W-1:0] second_func_oe;
	logic [W-1:0] second_func_o;

	// Word-index match on an aligned address
	function automatic logic reg_hit(input logic [15:0] idx, input logic [15:0] target,
		input logic ok);
		reg_hit = ok && (idx == target);
	endfunction : reg_hit

	// Decode of the APB request
	assign word_idx         = paddr[dgsp_pkg::APB_ADDR_W-1:dgsp_pkg::IDX_LSB];
	assign aligned          = (paddr[dgsp_pkg::IDX_LSB-1:0] == 2'h0);
	assign hit_first_latch  = reg_hit(word_idx, dgsp_pkg::IDX_FIRST_LATCH, aligned);
	assign hit_first_dir    = reg_hit(word_idx, dgsp_pkg::IDX_FIRST_DIR, aligned);
	assign hit_first_pu     = reg_hit(word_idx, dgsp_pkg::IDX_FIRST_PULLUP, aligned);
	assign hit_second_latch = reg_hit(word_idx, dgsp_pkg::IDX_SECOND_LATCH, aligned);
	assign hit_second_dir   = reg_hit(word_idx, dgsp_pkg::IDX_SECOND_DIR, aligned);
	assign hit_sgs          = reg_hit(word_idx, dgsp_pkg::IDX_LCD_PIN_CTRL, aligned);
	assign hit_any          = hit_first_latch | hit_first_dir | hit_first_pu |
	                          hit_second_latch | hit_second_dir | hit_sgs;
	assign setup_phase      = psel & ~penable;
	assign wr_en            = psel & penable & pwrite & pstrb[0] & hit_any;
	assign wbyte            = pwdata[W-1:0];

	// Zero-wait slave; data and error were captured in the setup cycle
	assign pready  = psel & penable;
	assign prdata  = rdata_reg;
	assign pslverr = slverr_reg;

	// Input synchronisers
	dgsp_sync #(
		.W (W)
	) u_sync_first (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (first_port_pin_i),
		.sync_out (first_pin_sync)
	);

	dgsp_sync #(
		.W (W)
	) u_sync_second (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (second_port_pin_i),
		.sync_out (second_pin_sync)
	);

	// Data reads mix latch and live pin per direction bit
	assign first_read_val  = (first_port_direction_reg & first_port_latch_reg) |
	                         (~first_port_direction_reg & first_pin_sync);
	assign second_read_val = (second_port_direction_reg & second_port_latch_reg) |
	                         (~second_port_direction_reg & second_pin_sync);

	// Read mux; direction registers are write-only
	always_comb begin
		rdata_next  = 32'h0000_0000;
		slverr_next = ~hit_any;
		if (hit_first_latch) begin
			rdata_next[W-1:0] = first_read_val;
		end else if (hit_first_dir) begin
			rdata_next[W-1:0] = dgsp_pkg::WO_READ_BACK;
		end else if (hit_first_pu) begin
			rdata_next[W-1:0] = first_port_pullup_ctrl_reg;
		end else if (hit_second_latch) begin
			rdata_next[W-1:0] = second_read_val;
		end else if (hit_second_dir) begin
			rdata_next[W-1:0] = dgsp_pkg::WO_READ_BACK;
		end else if (hit_sgs) begin
			rdata_next[3:0] = segment_select_code_reg;
		end
	end

	// Capture read answer during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg  <= 32'h0000_0000;
			slverr_reg <= 1'b0;
		end else if (setup_phase) begin
			rdata_reg  <= pwrite ? 32'h0000_0000 : rdata_next;
			slverr_reg <= slverr_next;
		end
	end

	// First port registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_port_latch_reg       <= dgsp_pkg::RST_LATCH;
			first_port_direction_reg   <= dgsp_pkg::RST_DIR;
			first_port_pullup_ctrl_reg <= dgsp_pkg::RST_PULLUP;
		end else if (wr_en) begin
			if (hit_first_latch)
				first_port_latch_reg <= wbyte;
			if (hit_first_dir)
				first_port_direction_reg <= wbyte;
			if (hit_first_pu)
				first_port_pullup_ctrl_reg <= wbyte;
		end
	end

	// Second port and segment select registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_port_latch_reg     <= dgsp_pkg::RST_LATCH;
			second_port_direction_reg <= dgsp_pkg::RST_DIR;
			segment_select_code_reg   <= dgsp_pkg::RST_SGS;
		end else if (wr_en) begin
			if (hit_second_latch)
				second_port_latch_reg <= wbyte;
			if (hit_second_dir)
				second_port_direction_reg <= wbyte;
			if (hit_sgs)
				segment_select_code_reg <= pwdata[3:0];
		end
	end

	// GPIO versus segment per port
	assign first_gpio  = (segment_select_code_reg[3:2] == 2'b00) ||
	                     (segment_select_code_reg[3:1] == 3'b010);
	assign second_gpio = (segment_select_code_reg[3:2] == 2'b00);

	// Mode qualifiers
	assign mode_standby = (pwr_mode == dgsp_pkg::MODE_STANDBY);
	assign mode_hold    = (pwr_mode == dgsp_pkg::MODE_SLEEP) ||
	                      (pwr_mode == dgsp_pkg::MODE_SUBSLEEP) ||
	                      (pwr_mode == dgsp_pkg::MODE_WATCH);

	// First port functional drive and pull-up
	assign first_func_oe = first_gpio ? first_port_direction_reg : {W{1'b1}};
	assign first_func_o  = first_gpio ? first_port_latch_reg : lcd_segment_output_first;
	assign first_func_pu = {W{first_gpio}} & ~first_port_direction_reg &
	                       first_port_pullup_ctrl_reg;

	// Second port functional drive, settings only in GPIO mode
	assign second_func_oe = second_gpio ? second_port_direction_reg : {W{1'b1}};
	assign second_func_o  = second_gpio ? second_port_latch_reg :
	                        lcd_segment_output_second;

	// First port pad stage
	dgsp_pin_stage #(
		.W (W)
	) u_stage_first (
		.pclk    (pclk),
		.presetn (presetn),
		.standby (mode_standby),
		.hold    (mode_hold),
		.func_oe (first_func_oe),
		.func_o  (first_func_o),
		.func_pu (first_func_pu),
		.pad_oe  (first_port_pin_oe),
		.pad_o   (first_port_pin_o),
		.pad_pu  (first_port_pin_pu)
	);

	// Second port pad stage, no pull-ups on these pins
	dgsp_pin_stage #(
		.W (W)
	) u_stage_second (
		.pclk    (pclk),
		.presetn (presetn),
		.standby (mode_standby),
		.hold    (mode_hold),
		.func_oe (second_func_oe),
		.func_o  (second_func_o),
		.func_pu ({W{1'b0}}),
		.pad_oe  (second_port_pin_oe),
		.pad_o   (second_port_pin_o),
		.pad_pu  ()
	);

	// Checks on pad behaviour and register access
	logic run_mode;
	assign run_mode = (pwr_mode == dgsp_pkg::MODE_ACTIVE) ||
	                  (pwr_mode == dgsp_pkg::MODE_SUBACTIVE);

	property p_pullup_follows;
		@(posedge pclk) disable iff (!presetn)
		(run_mode && first_gpio) |=>
			(first_port_pin_pu == ($past(first_port_pullup_ctrl_reg) &
			~$past(first_port_direction_reg)));
	endproperty
	a_pullup_follows: assert property (p_pullup_follows)
		else $error("pull-up does not follow control bit");

	property p_pullup_off_out;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> ((first_port_pin_pu & first_port_pin_oe) == '0);
	endproperty
	a_pullup_off_out: assert property (p_pullup_off_out)
		else $error("pull-up on while pin drives");

	property p_pullup_reset;
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> (first_port_pullup_ctrl_reg == dgsp_pkg::RST_PULLUP);
	endproperty
	a_pullup_reset: assert property (p_pullup_reset)
		else $error("pull-up register not cleared by reset");

	property p_first_seg;
		@(posedge pclk) disable iff (!presetn)
		(run_mode && (segment_select_code_reg[3] ||
			segment_select_code_reg[3:1] == 3'b011)) |=>
			(first_port_pin_oe == {W{1'b1}}) &&
			(first_port_pin_o == $past(lcd_segment_output_first));
	endproperty
	a_first_seg: assert property (p_first_seg)
		else $error("first port not driving segments");

	property p_standby_float;
		@(posedge pclk) disable iff (!presetn)
		mode_standby |=> (first_port_pin_oe == '0) && (second_port_pin_oe == '0);
	endproperty
	a_standby_float: assert property (p_standby_float)
		else $error("pin driven in standby");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		mode_hold[*2] |-> $stable(first_port_pin_oe) && $stable(second_port_pin_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("pins changed in a hold mode");

	property p_standby_pu;
		@(posedge pclk) disable iff (!presetn)
		mode_standby |=> (first_port_pin_pu == $past(first_func_pu));
	endproperty
	a_standby_pu: assert property (p_standby_pu)
		else $error("pull-up dropped in standby");

	property p_dir_reads_ones;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && (hit_second_dir || hit_first_dir)) |->
			(prdata[W-1:0] == dgsp_pkg::WO_READ_BACK) && !pslverr;
	endproperty
	a_dir_reads_ones: assert property (p_dir_reads_ones)
		else $error("direction register read not all ones");

	property p_second_read;
		@(posedge pclk) disable iff (!presetn)
		(setup_phase && !pwrite && hit_second_latch) ##1 pready |->
			(prdata[W-1:0] == $past(second_read_val));
	endproperty
	a_second_read: assert property (p_second_read)
		else $error("second data read wrong");

	property p_second_seg;
		@(posedge pclk) disable iff (!presetn)
		(run_mode && !second_gpio) |=> (second_port_pin_oe == {W{1'b1}});
	endproperty
	a_second_seg: assert property (p_second_seg)
		else $error("second port not in segment drive");

	property p_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(setup_phase && !hit_any) ##1 pready |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped access not flagged");

	// Main scenarios
	c_first_seg: cover property (@(posedge pclk) disable iff (!presetn)
		run_mode && !first_gpio);
	c_standby_pu: cover property (@(posedge pclk) disable iff (!presetn)
		mode_standby && (first_func_pu != '0));
	c_dir_write: cover property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_second_dir);

endmodule : dgsp_port

`default_nettype wire

/* tb/dgsp_pad_model.sv */
// Pad and external circuit model for one 8-bit port
`default_nettype none

module dgsp_pad_model (
	// Clock
	input  wire logic       pclk,
	// Device pad controls
	input  wire logic [7:0] oe,
	input  wire logic [7:0] o,
	input  wire logic [7:0] pu,
	// External drivers
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_d,
	// Resolved pin level
	output logic      [7:0] lvl
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] last_q = 8'h00;

	// Undriven bits toggle so a stale level never passes for a drive
	always @(posedge pclk) begin
		last_q <= lvl;
	end

	// Device drive wins, then external drive, then pull-up
	always_comb begin
		lvl = (oe & o) | (~oe & ext_en & ext_d) | (~oe & ~ext_en & pu)
			| (~oe & ~ext_en & ~pu & ~last_q);
	end

endmodule : dgsp_pad_model

`default_nettype wire

/* tb/dgsp_port_tb.sv */
// Self-checking testbench for the dual GPIO / segment port
`default_nettype none

module dgsp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [17:0] paddr = 18'h00000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  pstrb = 4'hF;
	logic [2:0]  pwr_mode = 3'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  seg1 = 8'h00, seg2 = 8'h00, e1_en = 8'hFF, e1_d = 8'h3C;
	logic [7:0]  e2_en = 8'hFF, e2_d = 8'hC3;
	logic [7:0]  p1_i, p1_o, p1_oe, p1_pu, p2_i, p2_o, p2_oe;
	logic [7:0]  dir1, lat1, pu1, dir2, lat2, x1, x2, s1, s2;
	logic [9:0]  exp_q[$];
	logic [9:0]  n;
	logic        g1, g2;
	int          fail_count = 0, checks = 0, cycles = 0, seed = 85;

	always #2 pclk = ~pclk;

	dgsp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pwr_mode(pwr_mode),
		.lcd_segment_output_first(seg1), .lcd_segment_output_second(seg2),
		.first_port_pin_i(p1_i), .first_port_pin_o(p1_o), .first_port_pin_oe(p1_oe),
		.first_port_pin_pu(p1_pu), .second_port_pin_i(p2_i), .second_port_pin_o(p2_o),
		.second_port_pin_oe(p2_oe));
	dgsp_pad_model u_pad1 (.pclk(pclk), .oe(p1_oe), .o(p1_o), .pu(p1_pu), .ext_en(e1_en),
		.ext_d(e1_d), .lvl(p1_i));
	dgsp_pad_model u_pad2 (.pclk(pclk), .oe(p2_oe), .o(p2_o), .pu(8'h00), .ext_en(e2_en),
		.ext_d(e2_d), .lvl(p2_i));

	// Compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Verdict and end of run
	task final_report;
		if (fail_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	// One APB transfer; the expected answer is queued first
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
			input logic [7:0] ed, input logic ee);
		@(posedge pclk);
		exp_q.push_back({wr, ee, ed});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 8'h00, 1'b0);
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [7:0] ed);
		apb(1'b0, idx, 8'h00, ed, 1'b0);
	endtask : rd

	// Pads and synchroniser catch up
	task settle;
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	// Completed transfers against the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			n = exp_q.pop_front();
			check("pslverr", {7'h00, pslverr}, {7'h00, n[8]});
			if (n[9] == 1'b0) begin
				check("prdata", prdata[7:0], n[7:0]);
			end
		end
	end

	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles > 5000) begin
			fail_count++;
			final_report;
		end
	end

	initial begin
		repeat (4) @(posedge pclk);
		#1;
		check("oe1 reset", p1_oe, 8'h00);
		check("oe2 reset", p2_oe, 8'h00);
		@(posedge pclk);
		presetn <= 1'b1;
		settle;
		// Reset values, read-back and unmapped access
		rd(dgsp_pkg::IDX_FIRST_LATCH, 8'h3C);
		rd(dgsp_pkg::IDX_FIRST_PULLUP, 8'h00);
		// Write with byte strobe off is ignored
		pstrb <= 4'h0;
		wr(dgsp_pkg::IDX_FIRST_PULLUP, 8'hA5);
		pstrb <= 4'hF;
		rd(dgsp_pkg::IDX_FIRST_PULLUP, 8'h00);
		rd(dgsp_pkg::IDX_SECOND_LATCH, 8'hC3);
		rd(dgsp_pkg::IDX_FIRST_DIR, 8'hFF);
		apb(1'b0, 16'hFFFF, 8'h00, 8'h00, 1'b1);
		apb(1'b1, 16'hFFFF, 8'h5A, 8'h00, 1'b1);
		wr(dgsp_pkg::IDX_SECOND_DIR, 8'hFF);
		rd(dgsp_pkg::IDX_SECOND_DIR, 8'hFF);
		rd(dgsp_pkg::IDX_SECOND_LATCH, 8'h00);
		// Mixed directions with random data
		dir1 = 8'($random(seed));
		lat1 = 8'($random(seed));
		pu1 = 8'($random(seed));
		dir2 = 8'($random(seed));
		lat2 = 8'($random(seed));
		x1 = 8'($random(seed));
		x2 = 8'($random(seed));
		@(posedge pclk);
		e1_en <= ~dir1;
		e1_d <= x1;
		e2_en <= ~dir2;
		e2_d <= x2;
		wr(dgsp_pkg::IDX_FIRST_DIR, dir1);
		wr(dgsp_pkg::IDX_FIRST_LATCH, lat1);
		wr(dgsp_pkg::IDX_FIRST_PULLUP, pu1);
		wr(dgsp_pkg::IDX_SECOND_DIR, dir2);
		wr(dgsp_pkg::IDX_SECOND_LATCH, lat2);
		settle;
		check("oe1", p1_oe, dir1);
		check("o1", p1_o, lat1);
		check("pu1 in", p1_pu & ~dir1, pu1 & ~dir1);
		check("pu1 out", p1_pu & dir1, 8'h00);
		check("oe2", p2_oe, dir2);
		check("o2", p2_o, lat2);
		rd(dgsp_pkg::IDX_FIRST_LATCH, (dir1 & lat1) | (~dir1 & x1));
		rd(dgsp_pkg::IDX_SECOND_LATCH, (dir2 & lat2) | (~dir2 & x2));
		rd(dgsp_pkg::IDX_FIRST_PULLUP, pu1);
		// Every segment-select code
		for (int c = 0; c < 16; c++) begin
			s1 = 8'($random(seed));
			s2 = 8'($random(seed));
			@(posedge pclk);
			seg1 <= s1;
			seg2 <= s2;
			wr(dgsp_pkg::IDX_LCD_PIN_CTRL, {4'h0, c[3:0]});
			settle;
			g1 = (c[3:2] == 2'b00) || (c[3:1] == 3'b010);
			g2 = (c[3:2] == 2'b00);
			check("oe1 seg", p1_oe, g1 ? dir1 : 8'hFF);
			check("o1 seg", p1_o, g1 ? lat1 : s1);
			check("oe2 seg", p2_oe, g2 ? dir2 : 8'hFF);
			check("o2 seg", p2_o, g2 ? lat2 : s2);
		end
		wr(dgsp_pkg::IDX_LCD_PIN_CTRL, 8'h00);
		// Standby: pads float, pulled inputs read high
		wr(dgsp_pkg::IDX_FIRST_PULLUP, 8'hFF);
		@(posedge pclk);
		pwr_mode <= dgsp_pkg::MODE_STANDBY;
		e1_en <= 8'h00;
		settle;
		check("oe1 stby", p1_oe, 8'h00);
		check("pu1 stby", p1_pu, ~dir1);
		check("oe2 stby", p2_oe, 8'h00);
		rd(dgsp_pkg::IDX_FIRST_LATCH, (dir1 & lat1) | ~dir1);
		// Back to active so the hold modes freeze functional values
		@(posedge pclk);
		pwr_mode <= dgsp_pkg::MODE_ACTIVE;
		e1_en <= ~dir1;
		settle;
		// Sleep, subsleep, watch freeze the pads
		for (int k = 2; k <= 4; k++) begin
			@(posedge pclk);
			pwr_mode <= k[2:0];
			wr(dgsp_pkg::IDX_SECOND_LATCH, ~lat2);
			wr(dgsp_pkg::IDX_FIRST_DIR, ~dir1);
			settle;
			check("o2 hold", p2_o, lat2);
			check("oe1 hold", p1_oe, dir1);
			lat2 = ~lat2;
			dir1 = ~dir1;
			@(posedge pclk);
			pwr_mode <= dgsp_pkg::MODE_SUBACTIVE;
			settle;
			check("o2 run", p2_o, lat2);
			check("oe1 run", p1_oe, dir1);
		end
		final_report;
	end

endmodule : dgsp_port_tb

`default_nettype wire
